/* design/program_space_map.vh */
// constants for the program space data access block
// How it works
// - fetch address is zero, pc bits 22..1, then a fixed zero lsb.
// - table address is the eight table page bits above ea bits 15..1 and a fixed zero lsb.
// - table page top bit zero selects user memory, one selects configuration memory.
// - configuration memory allows table reads only; table writes there are refused.
// - table operations accept unaligned addresses; configuration table reads are allowed.
// - word table_read_low returns program bits 15..0 unchanged.
// - byte table_read_low returns upper byte when select is one, else lower.
// - word table_read_high returns program bits 23..16 with upper data byte zero.
// - byte table_read_high gives selected byte in bits 7..0; phantom byte reads zero.
// - only high table ops touch bits 23..16; low ops touch the lower word.
// - program counter steps by two per program word.
// - window used only when ea msb is one and window_enable is set.
// - window covers data 8000h and up, one page of 16K words.
// - window page register picks one of 256 pages as upper address bits.
// - window address bit 15 is page bit 0; ea bit 15 ignored; bit 23 zero.
// - window reads return the lower 16 bits and cost a second fetch.
// - window access is disabled while a table read or write is in progress.
// - outside repeat, window adds one cycle for moves, two for others.
// - inside repeat, first, last, irq exit and reentry add two; others one, the second fetch, as for moves.
// - window accesses ignore ea msb and form 23-bit program addresses.
`ifndef PROGRAM_SPACE_MAP_VH
`define PROGRAM_SPACE_MAP_VH

// ******************************************
// register offsets (byte addresses)
// ******************************************
`define OFS_TABLE_PAGE 12'h000
`define OFS_WINDOW_PAGE 12'h004
`define OFS_CORE_CONTROL 12'h008
`define OFS_STATUS 12'h00C

// ******************************************
// fields and reset values
// ******************************************
`define WINDOW_ENABLE_BIT 2
`define TABLE_PAGE_RESET 8'h00
`define WINDOW_PAGE_RESET 8'h00
`define CORE_CONTROL_RESET 16'h0000

// ******************************************
// request kinds
// ******************************************
`define KIND_DATA 3'h0
`define KIND_TRD_LOW 3'h1
`define KIND_TRD_HIGH 3'h2
`define KIND_TWR_LOW 3'h3
`define KIND_TWR_HIGH 3'h4

// ******************************************
// extra cycle counts for window reads
// ******************************************
`define EXTRA_MOVE 2'h1
`define EXTRA_OTHER 2'h2
`define EXTRA_REPEAT_EDGE 2'h2
`define EXTRA_REPEAT_BODY 2'h0

`endif

/* design/program_space_data_access.v */
// program memory access paths for the cpu data side: fetch, table and window
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "program_space_map.vh"

module program_space_data_access (
    input wire ref_clk, // 200 MHz core clock
    input wire rst, // synchronous, active high
    // apb slave
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output wire pready, // apb ready
    output reg pslverr, // apb error on unmapped address
    // fetch path
    input wire [22:0] pc, // program counter
    output reg [23:0] fetch_addr, // instruction fetch address
    output reg [22:0] pc_next, // next sequential pc
    // cpu data request
    input wire req_valid, // request strobe, taken when idle
    input wire [2:0] req_kind, // data read or table op
    input wire req_byte, // byte mode
    input wire [15:0] req_ea, // data effective address
    input wire [15:0] req_wdata, // table write data
    input wire req_move, // plain or double_word_move instruction
    input wire in_repeat, // inside a repeat loop
    input wire rep_edge, // first, last, irq exit or reentry iteration
    input wire table_hold, // table read or write sequence in progress
    output wire cpu_wait, // wait request to the pipeline
    output reg cpu_done, // one-cycle completion pulse
    output reg [15:0] cpu_rdata, // read result
    output reg cpu_refused, // table write to configuration refused
    output reg window_hit, // completed access used the window
    // program memory array
    output reg mem_req, // memory fetch/write request
    output reg [23:0] mem_addr, // program word address
    output reg mem_we, // write
    output reg [2:0] mem_wmask, // byte lanes 23..16, 15..8, 7..0
    output reg [23:0] mem_wdata, // write data
    input wire mem_ack, // one-cycle answer
    input wire [23:0] mem_rdata // read word
);

    // one-hot states
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_FETCH1 = 5'h02;
    localparam [4:0] S_FETCH2 = 5'h04;
    localparam [4:0] S_STALL = 5'h08;
    localparam [4:0] S_DONE = 5'h10;

    reg [4:0] state_q;
    reg [7:0] table_page_reg;
    reg [7:0] window_page_reg;
    reg [15:0] core_control_reg;
    reg [2:0] kind_q;
    reg byte_q;
    reg bsel_q;
    reg win_q;
    reg [1:0] extra_q;
    reg [15:0] rdata_d;
    reg [23:0] word_q;

    // ******************************************
    // apb slave, zero wait states
    // ******************************************
    assign pready = 1'b1;
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite;
    wire mapped = (paddr == `OFS_TABLE_PAGE) || (paddr == `OFS_WINDOW_PAGE) ||
                  (paddr == `OFS_CORE_CONTROL) || (paddr == `OFS_STATUS);

    // read data captured in setup so it stands through the access edge
    always @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= ~mapped;
            if (paddr == `OFS_TABLE_PAGE) begin
                prdata <= {24'h000000, table_page_reg};
            end else if (paddr == `OFS_WINDOW_PAGE) begin
                prdata <= {24'h000000, window_page_reg};
            end else if (paddr == `OFS_CORE_CONTROL) begin
                prdata <= {16'h0000, core_control_reg};
            end else if (paddr == `OFS_STATUS) begin
                prdata <= {24'h000000, 1'b0, win_q, ~state_q[0], state_q};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // register writes take effect at the access edge
    always @(posedge ref_clk) begin
        if (rst) begin
            table_page_reg <= `TABLE_PAGE_RESET;
            window_page_reg <= `WINDOW_PAGE_RESET;
            core_control_reg <= `CORE_CONTROL_RESET;
        end else if (apb_wr) begin
            if (paddr == `OFS_TABLE_PAGE) begin
                table_page_reg <= pwdata[7:0];
            end else if (paddr == `OFS_WINDOW_PAGE) begin
                window_page_reg <= pwdata[7:0];
            end else if (paddr == `OFS_CORE_CONTROL) begin
                core_control_reg <= pwdata[15:0];
            end
        end
    end

    // ******************************************
    // fetch address and pc step
    // ******************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            fetch_addr <= 24'h000000;
            pc_next <= 23'h000000;
        end else begin
            fetch_addr <= {1'b0, pc[22:1], 1'b0};
            pc_next <= pc + 23'h000002;
        end
    end

    // ******************************************
    // request decode
    // ******************************************
    wire is_table = (req_kind != `KIND_DATA);
    wire is_twrite = (req_kind == `KIND_TWR_LOW) || (req_kind == `KIND_TWR_HIGH);
    wire cfg_space = table_page_reg[7];
    // a table hold masks the window so table and window never interleave
    wire win_use = (req_kind == `KIND_DATA) && req_ea[15] &&
                   core_control_reg[`WINDOW_ENABLE_BIT] && ~table_hold;
    // table address keeps page over ea; ea bit 0 picks the byte lane
    wire [23:0] table_addr = {table_page_reg, req_ea[15:1], 1'b0};
    // window drops ea bit 15: 23-bit address, page bit 0 lands at bit 15
    wire [23:0] win_addr = {1'b0, window_page_reg, req_ea[14:1], 1'b0};
    // extra stall cycles owed by a window read
    wire [1:0] extra_d = in_repeat ? (rep_edge ? `EXTRA_REPEAT_EDGE : `EXTRA_REPEAT_BODY)
                                   : (req_move ? `EXTRA_MOVE : `EXTRA_OTHER);

    // write lanes: low ops hit bits 15..0, high ops hit bits 23..16 only
    reg [2:0] wmask_d;
    always @* begin
        wmask_d = 3'h0;
        if (req_kind == `KIND_TWR_LOW) begin
            wmask_d = req_byte ? (req_ea[0] ? 3'h2 : 3'h1) : 3'h3;
        end else if (req_kind == `KIND_TWR_HIGH) begin
            wmask_d = (req_byte && req_ea[0]) ? 3'h0 : 3'h4;
        end
    end

    // read formatting of the fetched word
    always @* begin
        rdata_d = 16'h0000;
        if (kind_q == `KIND_TRD_LOW) begin
            if (byte_q) begin
                rdata_d = {8'h00, bsel_q ? word_q[15:8] : word_q[7:0]};
            end else begin
                rdata_d = word_q[15:0];
            end
        end else if (kind_q == `KIND_TRD_HIGH) begin
            // phantom byte reads as zero in both modes
            if (byte_q && bsel_q) begin
                rdata_d = 16'h0000;
            end else begin
                rdata_d = {8'h00, word_q[23:16]};
            end
        end else begin
            rdata_d = word_q[15:0];
        end
    end

    // ******************************************
    // access sequencer
    // ******************************************
    assign cpu_wait = ~state_q[0] & ~state_q[4];

    always @(posedge ref_clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            kind_q <= `KIND_DATA;
            byte_q <= 1'b0;
            bsel_q <= 1'b0;
            win_q <= 1'b0;
            extra_q <= 2'h0;
            word_q <= 24'h000000;
            mem_req <= 1'b0;
            mem_addr <= 24'h000000;
            mem_we <= 1'b0;
            mem_wmask <= 3'h0;
            mem_wdata <= 24'h000000;
            cpu_done <= 1'b0;
            cpu_rdata <= 16'h0000;
            cpu_refused <= 1'b0;
            window_hit <= 1'b0;
        end else begin
            cpu_done <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (req_valid) begin
                        kind_q <= req_kind;
                        byte_q <= req_byte;
                        bsel_q <= req_ea[0];
                        win_q <= win_use;
                        extra_q <= extra_d;
                        cpu_refused <= 1'b0;
                        if (is_twrite && cfg_space) begin
                            cpu_refused <= 1'b1;
                            state_q <= S_DONE;
                        end else if (is_table || win_use) begin
                            mem_req <= 1'b1;
                            mem_addr <= is_table ? table_addr : win_addr;
                            mem_we <= is_twrite;
                            mem_wmask <= wmask_d;
                            mem_wdata <= {req_wdata[7:0], req_byte ? req_wdata[7:0] :
                                          req_wdata[15:8], req_wdata[7:0]};
                            state_q <= S_FETCH1;
                        end else begin
                            // plain data access, nothing to redirect
                            state_q <= S_DONE;
                        end
                    end
                end
                S_FETCH1: begin
                    if (mem_ack) begin
                        word_q <= mem_rdata;
                        if (win_q) begin
                            state_q <= S_FETCH2;
                        end else begin
                            mem_req <= 1'b0;
                            mem_we <= 1'b0;
                            state_q <= S_DONE;
                        end
                    end
                end
                S_FETCH2: begin
                    // second fetch of the same word for a window read
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        word_q <= mem_rdata;
                        state_q <= (extra_q > 2'h1) ? S_STALL : S_DONE;
                    end
                end
                S_STALL: begin
                    state_q <= S_DONE;
                end
                S_DONE: begin
                    cpu_done <= 1'b1;
                    cpu_rdata <= rdata_d;
                    window_hit <= win_q;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule // program_space_data_access
`default_nettype wire

/* dv/psda_props.sv */
// checker of timing and data relations at the access block ports
`timescale 1ns/10ps
`default_nettype none
`include "program_space_map.vh"
module psda_props (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic [22:0] pc, // pc
    input wire logic [23:0] fetch_addr, // fetch
    input wire logic [22:0] pc_next, // pc plus two
    input wire logic [2:0] req_kind, // kind
    input wire logic req_byte, // byte mode
    input wire logic [15:0] req_ea, // ea
    input wire logic req_move, // move
    input wire logic in_repeat, // repeat
    input wire logic rep_edge, // repeat edge
    input wire logic cpu_wait, // stall
    input wire logic cpu_done, // done
    input wire logic [15:0] cpu_rdata, // result
    input wire logic cpu_refused, // refused
    input wire logic window_hit, // window used
    input wire logic mem_req, // mem request
    input wire logic [23:0] mem_addr, // mem address
    input wire logic mem_ack // mem answer
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    logic [1:0] acks_q;
    logic [2:0] since_q;
    logic long_w;
    // acks per operation and cycles since the last ack; saturate so a late done shows
    always_ff @(posedge ref_clk) begin
        if (rst || cpu_done) begin
            acks_q <= 2'h0;
        end else if (mem_ack && acks_q != 2'h3) begin
            acks_q <= acks_q + 2'h1;
        end
        if (rst) begin
            since_q <= 3'h7;
        end else if (mem_ack) begin
            since_q <= 3'h1;
        end else if (since_q != 3'h7) begin
            since_q <= since_q + 3'h1;
        end
    end
    // cases that cost two extra cycles
    assign long_w = in_repeat ? rep_edge : !req_move;
    sequence s_mem_waiting;
        mem_req && !mem_ack;
    endsequence
    sequence s_window_done;
        cpu_done && window_hit;
    endsequence
    AST_FETCH_ADDR: assert property (!$past(rst) |-> fetch_addr == ({1'b0, $past(pc)} & 24'h7FFFFE))
        else $error("fetch address not built from pc");
    AST_PC_STEP: assert property (!$past(rst) |-> pc_next == $past(pc) + 23'h2)
        else $error("next pc not two ahead");
    AST_MEM_HOLD: assert property (s_mem_waiting |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped before answer");
    AST_DONE_PULSE: assert property (cpu_done |-> !cpu_wait ##1 !cpu_done)
        else $error("done not a single cycle after stall");
    AST_REFUSE_NO_MEM: assert property (cpu_done && cpu_refused |-> !$past(mem_req) && !$past(mem_req, 2))
        else $error("refused write touched memory");
    AST_WINDOW_FETCHES: assert property (s_window_done |-> acks_q == 2'h2)
        else $error("window read without two fetches");
    AST_WINDOW_EXTRA: assert property (s_window_done |-> since_q == (long_w ? 3'h3 : 3'h2))
        else $error("window extra cycles wrong");
    AST_HIGH_PHANTOM: assert property (cpu_done && req_kind == `KIND_TRD_HIGH && !req_byte |-> cpu_rdata[15:8] == 8'h00)
        else $error("high read upper byte not zero");
    AST_PLAIN_DATA: assert property (cpu_done && req_kind == `KIND_DATA && !req_ea[15] |-> !window_hit)
        else $error("low data address used the window");
endmodule // psda_props
bind program_space_data_access psda_props u_psda_props (.ref_clk, .rst, .pc, .fetch_addr,
    .pc_next, .req_kind, .req_byte, .req_ea, .req_move, .in_repeat, .rep_edge, .cpu_wait,
    .cpu_done, .cpu_rdata, .cpu_refused, .window_hit, .mem_req, .mem_addr, .mem_ack);
`default_nettype wire

/* dv/prog_mem_model.sv */
// behavioural program memory array answering the access block
`timescale 1ns/10ps
`default_nettype none
module prog_mem_model (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic [1:0] lag, // answer delay
    input wire logic mem_req, // request
    input wire logic [23:0] mem_addr, // address
    input wire logic mem_we, // write
    input wire logic [2:0] mem_wmask, // lanes
    input wire logic [23:0] mem_wdata, // write data
    output logic mem_ack, // answer
    output logic [23:0] mem_rdata // read word
);
    logic [23:0] mem [int];
    logic [23:0] key;
    int wait_q;
    assign key = {mem_addr[23:1], 1'b0};
    // answer after lag cycles; read bus toggles junk when not answering
    always @(posedge ref_clk) begin
        mem_rdata <= ~mem_rdata;
        if (rst || mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            wait_q <= 0;
            if (rst) mem_rdata <= 24'h0;
        end else if (wait_q < lag) begin
            wait_q <= wait_q + 1;
        end else begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[key];
            for (int i = 0; i < 3; i++) begin
                if (mem_we && mem_wmask[i]) mem[key][i*8+:8] = mem_wdata[i*8+:8];
            end
        end
    end
endmodule // prog_mem_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench: register, fetch, table and window scenarios
`timescale 1ns/10ps
`default_nettype none
`include "program_space_map.vh"
module testbench;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, req_valid, req_byte, req_move;
    logic in_repeat, rep_edge, table_hold, cpu_wait, cpu_done, cpu_refused, window_hit;
    logic mem_req, mem_we, mem_ack, err, wen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [22:0] pc, pc_next;
    logic [23:0] fetch_addr, mem_addr, mem_wdata, mem_rdata;
    logic [15:0] req_ea, req_wdata, cpu_rdata;
    logic [2:0] req_kind, mem_wmask;
    logic [7:0] tpage, wpage;
    logic [1:0] lag;
    logic [23:0] pm [int];
    int fails, check_count, seed;
    program_space_data_access u_program_space_data_access (.ref_clk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pc, .fetch_addr, .pc_next,
        .req_valid, .req_kind, .req_byte, .req_ea, .req_wdata, .req_move, .in_repeat,
        .rep_edge, .table_hold, .cpu_wait, .cpu_done, .cpu_rdata, .cpu_refused, .window_hit,
        .mem_req, .mem_addr, .mem_we, .mem_wmask, .mem_wdata, .mem_ack, .mem_rdata);
    prog_mem_model u_prog_mem_model (.ref_clk, .rst, .lag, .mem_req, .mem_addr, .mem_we,
        .mem_wmask, .mem_wdata, .mem_ack, .mem_rdata);
    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ************************************
    // tasks
    // ************************************
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // apb transfer; pready sampled at the edge, data taken there
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task setup(input logic [7:0] tp, input logic [7:0] wp, input logic en);
        tpage = tp;
        wpage = wp;
        wen = en;
        apb(1'b1, 12'h000, {24'h0, tp});
        apb(1'b1, 12'h004, {24'h0, wp});
        apb(1'b1, 12'h008, {29'h0, en, 2'h0});
        apb(1'b0, 12'h004, 32'h0);
        chk("window page", {24'h0, wp}, rd);
    endtask
    // model word; new words also loaded into the memory model
    function automatic logic [23:0] word(input logic [23:0] a, input logic fill);
        logic [23:0] k;
        k = {a[23:1], 1'b0};
        if (!pm.exists(k)) begin
            pm[k] = 24'($random(seed));
            if (fill) pm[k][23:16] = {8{pm[k][0]}};
            u_prog_mem_model.mem[k] = pm[k];
        end
        return pm[k];
    endfunction
    // one request; inputs held until the next one
    task op(input logic [2:0] k, input logic b, input logic [15:0] ea, input logic [15:0] wd);
        @(posedge ref_clk);
        req_kind <= k;
        req_byte <= b;
        req_ea <= ea;
        req_wdata <= wd;
        req_valid <= 1'b1;
        lag <= 2'($random(seed));
        @(posedge ref_clk);
        req_valid <= 1'b0;
        for (int i = 0; i < 200 && cpu_done !== 1'b1; i++) @(posedge ref_clk);
        chk("done", 32'h1, {31'h0, cpu_done});
    endtask
    task tbl(input logic [2:0] k, input logic b, input logic [15:0] ea, input logic [15:0] wd);
        logic [23:0] w;
        logic [15:0] e;
        logic [15:0] m;
        w = word({tpage, ea}, 1'b0);
        m = b ? 16'h00FF : 16'hFFFF;
        op(k, b, ea, wd);
        e = {8'h00, (b && ea[0]) ? 8'h00 : w[23:16]};
        if (k == `KIND_TRD_LOW) e = b ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w[15:0];
        if (k < `KIND_TWR_LOW) chk("table read", e & m, cpu_rdata & m);
        if (k >= `KIND_TWR_LOW) begin
            if (k == `KIND_TWR_HIGH && !(b && ea[0])) w[23:16] = wd[7:0];
            if (k == `KIND_TWR_LOW && !b) w[15:0] = wd;
            if (k == `KIND_TWR_LOW && b && ea[0]) w[15:8] = wd[7:0];
            if (k == `KIND_TWR_LOW && b && !ea[0]) w[7:0] = wd[7:0];
            if (!tpage[7]) pm[{tpage, ea[15:1], 1'b0}] = w;
            chk("refused", {31'h0, tpage[7]}, {31'h0, cpu_refused});
        end
    endtask
    task win(input logic [15:0] ea, input logic [3:0] ctl);
        logic [23:0] w;
        w = word({1'b0, wpage, ea[14:0]}, 1'b1);
        @(posedge ref_clk);
        {req_move, in_repeat, rep_edge, table_hold} <= ctl;
        op(`KIND_DATA, 1'b0, ea, 16'h0);
        chk("window hit", {31'h0, wen && ea[15] && !ctl[0]}, {31'h0, window_hit});
        if (wen && ea[15] && !ctl[0]) chk("window data", {16'h0, w[15:0]}, {16'h0, cpu_rdata});
    endtask
    task wrap_up;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ************************************
    // scenarios
    // ************************************
    initial begin
        seed = 21;
        {fails, check_count} = '0;
        {rst, psel, penable, pwrite, req_valid, req_byte, req_move} = 7'h40;
        {in_repeat, rep_edge, table_hold, paddr, pwdata, pc, req_kind, req_ea, req_wdata, lag} = '0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        // status shows only the one-hot idle state after reset
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("register reset", (i == 3) ? 32'h00000001 : 32'h00000000, rd);
            chk("mapped error", 32'h0, {31'h0, err});
        end
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            pc <= 23'($random(seed));
            repeat (2) @(posedge ref_clk);
            chk("fetch address", {8'h0, pc[22:1], 1'b0}, {8'h0, fetch_addr});
            chk("next pc", {9'h0, pc + 23'h2}, {9'h0, pc_next});
        end
        $display("fetch test done");
        // user and configuration pages alternate every eight loop passes; writes are read back both halves
        for (int i = 0; i < 32; i++) begin
            if (i % 8 == 0) setup({i[3], 7'($random(seed))}, 8'h00, 1'b0);
            tbl(3'(1 + i % 4), i[2], 16'($random(seed)), 16'($random(seed)));
            if (i % 4 > 1) tbl(`KIND_TRD_LOW, 1'b0, req_ea, 16'h0);
            if (i % 4 > 1) tbl(`KIND_TRD_HIGH, 1'b0, req_ea, 16'h0);
        end
        $display("table test done");
        setup(8'h00, 8'($random(seed)), 1'b1);
        for (int i = 0; i < 16; i++) win({i != 6, 15'($random(seed))}, {i[2:0], i[3] & i[0]});
        setup(8'h00, wpage, 1'b0);
        win(16'hC000, 4'h0);
        // idle again, and the last access did not use the window
        apb(1'b0, 12'h00C, 32'h0);
        chk("status idle", 32'h00000001, rd);
        $display("window test done");
        wrap_up;
    end
    // hang guard
    initial begin
        repeat (30000) @(posedge ref_clk);
        fails++;
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
